/* File: hw/cpu_interrupt_sequencer.v */
// interrupt acceptance and sequencing for an 8-bit core: enables, priority,
// vector relocation, flag and level sources, entry and return sequences.
// assumes one clock; the pipeline pulses instrDone at each instruction end
// and holds while stall is high; stack memory answers reads one cycle later.
`timescale 1ns/100ps
`default_nettype none
`include "cpu_interrupt_sequencer_map.vh"

// Summary of operation
// - accept only when source and global enabled
// - lowest vector index wins, reset highest
// - vector select moves vectors to boot start
// - boot reset fuse moves reset vector
// - accepting clears global enable
// - global enable in handler allows nesting
// - return instruction sets global enable
// - vectoring clears the flag of flag sources
// - writing one clears a flag, zero keeps
// - disabled source events still set flags
// - pending flags served later by priority
// - level sources request only while present
// - one instruction runs after each return
// - status flags never saved nor restored
// - disable instruction blocks same-cycle requests
// - instruction after enable completes first
// - entry takes four cycles, pushes pc
// - multi-cycle instructions finish before entry
// - wake from sleep adds four cycles
// - return takes four cycles, pops pc
// - boot lock bits suppress interrupts by pc
// - entry push lowers stack pointer by two
module cpu_interrupt_sequencer
(
  input  wire        clk_sys,            // cpu clock, 200 MHz
  input  wire        resetn,             // synchronous reset, active low
  input  wire        psel,               // apb select
  input  wire        penable,            // apb access phase
  input  wire        pwrite,             // apb write
  input  wire [7:0]  paddr,              // apb byte address
  input  wire [31:0] pwdata,             // apb write data
  output reg  [31:0] prdata,             // apb read data
  output reg         pready,             // apb ready
  output reg         pslverr,            // apb error on unmapped address
  input  wire [7:0]  srcEvent,           // flag-type event pulses
  input  wire [7:0]  srcLevel,           // level-type conditions
  output reg  [7:0]  srcAck,             // one-cycle pulse to the served source
  input  wire        instrDone,          // pulse at end of an instruction
  input  wire        instrCli,           // with instrDone: global disable
  input  wire        instrSei,           // with instrDone: global enable
  input  wire        instrReti,          // with instrDone: return from interrupt
  input  wire        coreSleeping,       // core is asleep, awaiting wake
  input  wire [15:0] pcCurrent,          // return address to push
  input  wire        pcInBoot,           // pc lies in the boot section
  input  wire        bootResetFuse,      // boot reset fuse programmed
  input  wire        appBootLockBit,     // app lock bit programmed
  input  wire        bootSectionLockBit, // boot lock bit programmed
  input  wire [7:0]  stackRdata,         // stack read data, one cycle late
  output reg         stackWe,            // stack write strobe
  output reg         stackRe,            // stack read strobe
  output reg  [15:0] stackAddr,          // stack byte address
  output reg  [7:0]  stackWdata,         // stack write data
  output reg         pcLoad,             // one-cycle pulse: load pcVector
  output reg  [15:0] pcVector,           // new program counter
  output reg         stall,              // pipeline hold
  output reg         globalEnable        // global interrupt enable bit
);

  localparam ST_RST   = 4'b0001;
  localparam ST_IDLE  = 4'b0010;
  localparam ST_ENTRY = 4'b0100;
  localparam ST_RET   = 4'b1000;

  reg  [3:0]  state;
  reg  [3:0]  cnt;
  reg  [3:0]  entryLast;
  reg         vecSel;
  reg  [7:0]  srcEnable;
  reg  [7:0]  flag;
  reg  [7:0]  levelType;
  reg  [15:0] sp;
  reg  [2:0]  curSrc;
  reg         blockOne;
  reg  [15:0] pcSave;
  reg  [7:0]  popHigh;
  reg  [2:0]  winner;
  reg  [31:0] rdMux;
  reg         rdErr;
  wire [7:0]  req;
  wire [7:0]  nextFlag;
  wire [7:0]  hwClr;
  wire        anyReq;
  wire        lockBlock;
  wire        boundary;
  wire        accept;
  wire        apbWr;
  wire        apbRd;
  wire        retStart;
  wire [15:0] vecBase;
  integer     k;

  // apb access strobes, one per transfer
  assign apbWr = psel & penable & pwrite & ~pready;
  assign apbRd = psel & penable & ~pwrite & ~pready;

  // request per source and flag update per bit
  genvar i;
  generate
    for (i = 0; i < `NUM_SRC; i = i + 1)
    begin : gen_src
      assign req[i] = srcEnable[i] & (levelType[i] ? srcLevel[i] : flag[i]);
      assign hwClr[i] = accept & (winner == i) & ~levelType[i];
      assign nextFlag[i] = (srcEvent[i] & ~levelType[i]) ? 1'b1 :
                           ((apbWr & (paddr == `OFS_FLAG) & pwdata[i]) | hwClr[i]) ? 1'b0 :
                           flag[i];
    end
  endgenerate

  assign anyReq = |req;

  // fixed priority: lowest index is the lowest vector address
  always @*
  begin
    winner = 3'd0;
    for (k = `NUM_SRC - 1; k >= 0; k = k - 1)
    begin
      if (req[k])
        winner = k[2:0];
    end
  end

  // boot lock bits block interrupts while executing in a locked section that does not hold the vectors
  assign lockBlock = vecSel ? (~pcInBoot & appBootLockBit)
                            : (pcInBoot & bootSectionLockBit);

  // accept only at an instruction end, or from sleep once the block clears
  assign boundary = instrDone ? ~instrReti : (coreSleeping & ~blockOne);
  assign accept   = (state == ST_IDLE) & globalEnable & ~(instrDone & instrCli)
                    & ~lockBlock & anyReq & boundary;
  assign retStart = (state == ST_IDLE) & instrDone & instrReti;

  assign vecBase = vecSel ? `BOOT_START : `APP_START;

  // flag, enable and type registers
  always @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      flag      <= 8'h00;
      srcEnable <= `RST_ENABLE;
      levelType <= `RST_LEVELTYPE;
      vecSel    <= 1'b0;
    end
    else
    begin
      flag <= nextFlag;
      if (apbWr && paddr == `OFS_ENABLE)
        srcEnable <= pwdata[7:0];
      if (apbWr && paddr == `OFS_LEVELTYPE)
        levelType <= pwdata[7:0];
      if (apbWr && paddr == `OFS_CTRL)
        vecSel <= pwdata[`CTRL_VSEL_BIT];
    end
  end

  // global enable: entry clears, disable clears, enable and return set
  always @(posedge clk_sys)
  begin
    if (!resetn)
      globalEnable <= 1'b0;
    else if (accept)
      globalEnable <= 1'b0;
    else if (state == ST_RET && cnt == `RET_CYCLES - 4'd1)
      globalEnable <= 1'b1;
    else if (instrDone && instrCli)
      globalEnable <= 1'b0;
    else if (instrDone && instrSei)
      globalEnable <= 1'b1;
    else if (apbWr && paddr == `OFS_CTRL)
      globalEnable <= pwdata[`CTRL_GIE_BIT];
  end

  // one-instruction guard after return or enable, released by instrDone
  always @(posedge clk_sys)
  begin
    if (!resetn)
      blockOne <= 1'b0;
    else if (state == ST_RET && cnt == `RET_CYCLES - 4'd1)
      blockOne <= 1'b1;
    else if (instrDone && instrSei)
      blockOne <= 1'b1;
    else if (instrDone)
      blockOne <= 1'b0;
  end

  // sequencer: reset vector, entry push, return pop
  // the status flags register is left alone in both sequences
  always @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      state      <= ST_RST;
      cnt        <= 4'd0;
      entryLast  <= 4'd0;
      curSrc     <= 3'd0;
      pcSave     <= 16'h0000;
      popHigh    <= 8'h00;
      sp         <= `RST_SP;
      stackWe    <= 1'b0;
      stackRe    <= 1'b0;
      stackAddr  <= 16'h0000;
      stackWdata <= 8'h00;
      pcLoad     <= 1'b0;
      pcVector   <= 16'h0000;
      stall      <= 1'b1;
      srcAck     <= 8'h00;
    end
    else
    begin
      stackWe <= 1'b0;
      stackRe <= 1'b0;
      pcLoad  <= 1'b0;
      srcAck  <= 8'h00;
      if (apbWr && paddr == `OFS_SP && state == ST_IDLE && !accept && !retStart)
        sp <= pwdata[15:0];
      case (state)
        ST_RST:
        begin
          pcLoad   <= 1'b1;
          pcVector <= bootResetFuse ? `BOOT_START : `APP_START;
          stall    <= 1'b0;
          state    <= ST_IDLE;
        end
        ST_IDLE:
        begin
          if (accept)
          begin
            state     <= ST_ENTRY;
            cnt       <= 4'd0;
            entryLast <= coreSleeping ? (`ENTRY_CYCLES + `WAKE_EXTRA - 4'd1)
                                      : (`ENTRY_CYCLES - 4'd1);
            curSrc    <= winner;
            pcSave    <= pcCurrent;
            stall     <= 1'b1;
            srcAck    <= 8'h01 << winner;
          end
          else if (retStart)
          begin
            state <= ST_RET;
            cnt   <= 4'd0;
            stall <= 1'b1;
          end
        end
        ST_ENTRY:
        begin
          cnt <= cnt + 4'd1;
          if (cnt == entryLast - 4'd2)
          begin
            stackWe    <= 1'b1;
            stackAddr  <= sp;
            stackWdata <= pcSave[7:0];
          end
          else if (cnt == entryLast - 4'd1)
          begin
            stackWe    <= 1'b1;
            stackAddr  <= sp - 16'h0001;
            stackWdata <= pcSave[15:8];
            sp         <= sp - 16'h0002;
          end
          else if (cnt == entryLast)
          begin
            pcLoad   <= 1'b1;
            pcVector <= vecBase + {11'h000, {1'b0, curSrc} + 4'd1, 1'b0};
            stall    <= 1'b0;
            state    <= ST_IDLE;
          end
        end
        ST_RET:
        begin
          cnt <= cnt + 4'd1;
          if (cnt == 4'd0)
          begin
            stackRe   <= 1'b1;
            stackAddr <= sp + 16'h0001;
          end
          else if (cnt == 4'd1)
          begin
            stackRe   <= 1'b1;
            stackAddr <= sp + 16'h0002;
          end
          else if (cnt == 4'd2)
            popHigh <= stackRdata; // byte at sp+1 arrives the cycle after its strobe
          else
          begin
            pcLoad   <= 1'b1;
            pcVector <= {popHigh, stackRdata};
            sp       <= sp + 16'h0002;
            stall    <= 1'b0;
            state    <= ST_IDLE;
          end
        end
        default:
        begin
          state <= ST_RST;
          stall <= 1'b1;
        end
      endcase
    end
  end

  // read mux and unmapped-address decode
  always @*
  begin
    rdMux = 32'h00000000;
    rdErr = 1'b0;
    case (paddr)
      `OFS_CTRL:
      begin
        rdMux[`CTRL_GIE_BIT]  = globalEnable;
        rdMux[`CTRL_VSEL_BIT] = vecSel;
      end
      `OFS_ENABLE:    rdMux[7:0]  = srcEnable;
      `OFS_FLAG:      rdMux[7:0]  = flag;
      `OFS_LEVELTYPE: rdMux[7:0]  = levelType;
      `OFS_SP:        rdMux[15:0] = sp;
      `OFS_STATUS:
      begin
        rdMux[`STAT_BUSY_BIT]  = stall;
        rdMux[`STAT_ENTRY_BIT] = (state == ST_ENTRY);
        rdMux[`STAT_RET_BIT]   = (state == ST_RET);
        rdMux[`STAT_BLOCK_BIT] = blockOne;
        rdMux[`STAT_SRC_LSB + 2:`STAT_SRC_LSB] = curSrc;
      end
      default:        rdErr = 1'b1;
    endcase
  end

  // apb answer: one wait state, ready in the second access cycle
  always @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end
    else
    begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & rdErr;
      if (apbRd)
        prdata <= rdErr ? 32'h00000000 : rdMux;
    end
  end

endmodule

`default_nettype wire

/* File: common/cpu_interrupt_sequencer_map.vh */
// register map, field positions, reset values and timing counts of the
// interrupt sequencer; assumes 32-bit apb data with word-aligned registers
`ifndef CPU_INTERRUPT_SEQUENCER_MAP_VH
`define CPU_INTERRUPT_SEQUENCER_MAP_VH

// number of peripheral sources, source 0 is external request zero
`define NUM_SRC          8

// register byte offsets
`define OFS_CTRL         8'h00
`define OFS_ENABLE       8'h04
`define OFS_FLAG         8'h08
`define OFS_LEVELTYPE    8'h0c
`define OFS_SP           8'h10
`define OFS_STATUS       8'h14

// core control register fields
`define CTRL_GIE_BIT     0
`define CTRL_VSEL_BIT    1

// status register fields
`define STAT_BUSY_BIT    0
`define STAT_ENTRY_BIT   1
`define STAT_RET_BIT     2
`define STAT_BLOCK_BIT   3
`define STAT_SRC_LSB     8

// reset values
`define RST_ENABLE       8'h00
`define RST_LEVELTYPE    8'h00
`define RST_SP           16'h0000

// program addresses
`define APP_START        16'h0000
`define BOOT_START       16'h3800

// cycle counts (one cycle is one cpu clock)
`define ENTRY_CYCLES     4'd4
`define WAKE_EXTRA       4'd4
`define RET_CYCLES       4'd4

`endif

/* File: sim/cpu_interrupt_sequencer_assertions.sv */
// timing checks on entry, return and gating of the sequencer
// assumes one clock and a synchronous active-low reset
`timescale 1ns/100ps
`default_nettype none
`include "cpu_interrupt_sequencer_map.vh"
module cpu_interrupt_sequencer_assertions
(
  input wire logic        clk_sys,       // cpu clock
  input wire logic        resetn,        // reset, active low
  input wire logic [7:0]  srcAck,        // served source
  input wire logic        instrDone,     // instruction end
  input wire logic        instrCli,      // global disable
  input wire logic        instrSei,      // global enable
  input wire logic        instrReti,     // return
  input wire logic        coreSleeping,  // core asleep
  input wire logic [15:0] pcCurrent,     // return address
  input wire logic        bootResetFuse, // reset vector moved
  input wire logic [7:0]  stackRdata,    // stack read data
  input wire logic        stackWe,       // stack write
  input wire logic        stackRe,       // stack read
  input wire logic [15:0] stackAddr,     // stack address
  input wire logic [7:0]  stackWdata,    // stack write data
  input wire logic        pcLoad,        // vector load
  input wire logic [15:0] pcVector,      // new pc
  input wire logic        stall,         // pipeline hold
  input wire logic        globalEnable   // global enable
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // push of the return address, low byte first, core awake
  sequence push_s;
    ##2 stackWe && {8'h00, stackWdata} == ($past(pcCurrent, 3) & 16'h00ff)
    ##1 stackWe && stackAddr == $past(stackAddr) - 16'h0001
      && {stackWdata, 8'h00} == ($past(pcCurrent, 4) & 16'hff00);
  endsequence
  // same push after a wake from sleep, four cycles later
  sequence push_wake_s;
    ##6 stackWe && {8'h00, stackWdata} == ($past(pcCurrent, 7) & 16'h00ff)
    ##1 stackWe && stackAddr == $past(stackAddr) - 16'h0001
      && {stackWdata, 8'h00} == ($past(pcCurrent, 8) & 16'hff00);
  endsequence
  // pop of two bytes from rising addresses
  sequence pop_s;
    stall && !stackRe ##1 stackRe ##1 stackRe && stackAddr == $past(stackAddr) + 16'h0001
    ##1 stall && !stackRe;
  endsequence
  // checks
  gie_cleared_a:
  assert property (srcAck != 8'h00 |-> $past(globalEnable) && !globalEnable)
    else $error("entry without global enable or enable left set");
  single_winner_a:
  assert property (srcAck != 8'h00 |-> $onehot(srcAck)) else $error("several sources acked");
  entry_awake_a:
  assert property (srcAck != 8'h00 && !$past(coreSleeping) |-> stall [*4] ##1 pcLoad && !stall)
    else $error("entry length wrong");
  entry_wake_a:
  assert property (srcAck != 8'h00 && $past(coreSleeping) |-> stall [*8] ##1 pcLoad && !stall)
    else $error("wake entry length wrong");
  push_order_a:
  assert property (srcAck != 8'h00 && !$past(coreSleeping) |-> push_s)
    else $error("return address push wrong");
  push_wake_a:
  assert property (srcAck != 8'h00 && $past(coreSleeping) |-> push_wake_s)
    else $error("return address push after wake wrong");
  boundary_only_a:
  assert property (srcAck != 8'h00 |-> $past(instrDone) || $past(coreSleeping))
    else $error("entry inside an instruction");
  reset_vector_a:
  assert property ($rose(resetn) |-> ##1 pcLoad
    && pcVector == (bootResetFuse ? `BOOT_START : `APP_START)) else $error("reset vector wrong");
  cli_blocks_a:
  assert property (instrDone && instrCli |=> srcAck == 8'h00 && !globalEnable)
    else $error("entry after global disable");
  sei_defer_a:
  assert property (instrDone && instrSei && !globalEnable |=> !stall && srcAck == 8'h00
    ##1 (srcAck == 8'h00 || $past(instrDone)))
    else $error("entry right after global enable");
  return_seq_a:
  assert property (instrDone && instrReti && !stall |=> pop_s ##1 pcLoad && !stall
    && globalEnable && pcVector == {$past(stackRdata, 2), $past(stackRdata)})
    else $error("return sequence wrong");
endmodule
`default_nettype wire

/* File: sim/stack_ram_model.sv */
// byte-wide stack memory behind the sequencer's stack port
// assumes reads are answered one cycle after the strobe
`timescale 1ns/100ps
`default_nettype none
module stack_ram_model
(
  input  wire logic        clk_sys,    // cpu clock
  input  wire logic        stackWe,    // write strobe
  input  wire logic        stackRe,    // read strobe
  input  wire logic [15:0] stackAddr,  // byte address
  input  wire logic [7:0]  stackWdata, // write data
  output var  logic [7:0]  stackRdata  // read data, one cycle late
);
  logic [7:0] mem [0:65535];
  initial stackRdata = 8'h00;
  // store writes; outside reads the data line toggles so stale bytes show
  always @(posedge clk_sys)
  begin
    if (stackWe)
      mem[stackAddr] <= stackWdata;
    stackRdata <= stackRe ? mem[stackAddr] : ~stackRdata;
  end
endmodule
`default_nettype wire

/* File: sim/cpu_interrupt_sequencer_bench.sv */
// self-checking bench of the sequencer with a stack model
// assumes the stack model of stack_ram_model.sv
`timescale 1ns/100ps
`default_nettype none
`include "cpu_interrupt_sequencer_map.vh"
module cpu_interrupt_sequencer_bench;
  logic        clk_sys = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00, srcEvent = 8'h00, srcLevel = 8'h00, ack;
  logic [31:0] pwdata = 32'h0, rdData;
  logic        instrDone = 1'b0, instrCli = 1'b0, instrSei = 1'b0, instrReti = 1'b0;
  logic        coreSleeping = 1'b0, errSeen, vs = 1'b0;
  logic        pcInBoot = 1'b0, bootResetFuse = 1'b1, appBootLockBit = 1'b0;
  logic        bootSectionLockBit = 1'b0;
  logic [15:0] pcCurrent = 16'h0000, rnd = 16'h0014;
  logic [15:0] pcQ [$];
  wire  [31:0] prdata;
  wire  [15:0] stackAddr, pcVector;
  wire  [7:0]  srcAck, stackRdata, stackWdata;
  wire         pready, pslverr, stackWe, stackRe, pcLoad, stall, globalEnable;
  int          error_cnt = 0, checked = 0, expFlag, i, n, k;
  // clock and design
  always #2.5 clk_sys = ~clk_sys;
  cpu_interrupt_sequencer cpu_interrupt_sequencer_i (.clk_sys, .resetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .srcEvent, .srcLevel, .srcAck,
    .instrDone, .instrCli, .instrSei, .instrReti, .coreSleeping, .pcCurrent, .pcInBoot,
    .bootResetFuse, .appBootLockBit, .bootSectionLockBit, .stackRdata,
    .stackWe, .stackRe, .stackAddr, .stackWdata, .pcLoad, .pcVector, .stall, .globalEnable);
  stack_ram_model stack_ram_model_i (.clk_sys, .stackWe, .stackRe, .stackAddr, .stackWdata,
    .stackRdata);
  // compare, pseudo random, bus and pipeline helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int w;
    w = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1 && w < 20)
    begin
      @(posedge clk_sys);
      w++;
    end
    if (pready !== 1'b1)
      error_cnt++;
    rdData = prdata;
    errSeen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic step(input logic c, input logic s, input logic r);
    @(posedge clk_sys);
    instrDone <= 1'b1;
    instrCli <= c;
    instrSei <= s;
    instrReti <= r;
    @(posedge clk_sys);
    instrDone <= 1'b0;
  endtask
  task automatic land;
    ack = 8'h00;
    for (int w = 0; w < 30 && pcLoad !== 1'b1; w++)
    begin
      @(posedge clk_sys);
      if (srcAck !== 8'h00)
        ack = srcAck;
    end
    if (pcLoad !== 1'b1)
      error_cnt++;
  endtask
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // watchdog
  initial
  begin
    #100000;
    error_cnt++;
    summarize;
  end
  // main sequence
  initial
  begin
    repeat (6) @(posedge clk_sys);
    resetn <= 1'b1;
    land;
    chk(pcVector, `BOOT_START);
    apb(0, `OFS_LEVELTYPE, 0);
    chk(rdData, `RST_LEVELTYPE);
    apb(1, 8'h40, 32'h1);
    chk(errSeen, 1'b1);
    $display("reset test done");
    apb(1, `OFS_LEVELTYPE, 32'h80);
    rnd = lfsr(rnd);
    @(posedge clk_sys) srcEvent <= rnd[7:0] | 8'h55;
    @(posedge clk_sys) srcEvent <= 8'h00;
    srcLevel <= 8'h80;
    expFlag = (rnd[7:0] | 8'h55) & 8'h7f;
    apb(0, `OFS_FLAG, 0);
    srcLevel <= 8'h00;
    chk(rdData, expFlag);
    apb(1, `OFS_FLAG, 32'h0f);
    expFlag &= 8'h70;
    apb(0, `OFS_FLAG, 0);
    chk(rdData, expFlag);
    $display("flag test done");
    apb(1, `OFS_ENABLE, 32'hff);
    apb(1, `OFS_SP, 32'h0100);
    apb(1, `OFS_CTRL, 32'h1);
    rnd = lfsr(rnd);
    pcCurrent <= rnd;
    pcQ.push_back(rnd);
    coreSleeping <= 1'b1;
    n = 0;
    while (expFlag != 0 && n < 8)
    begin
      land;
      coreSleeping <= 1'b0;
      for (k = 7; k >= 0; k--)
        if (expFlag[k])
          i = k;
      chk(ack, 8'h01 << i);
      chk(pcVector, (vs ? `BOOT_START : `APP_START) + 2 * (i + 1));
      expFlag[i] = 0;
      apb(0, `OFS_FLAG, 0);
      chk(rdData, expFlag);
      apb(0, `OFS_SP, 0);
      chk(rdData, 32'h00fe);
      vs = ~vs;
      apb(1, `OFS_CTRL, {30'h0, vs, 1'b0});
      step(0, 0, 1);
      land;
      coreSleeping <= 1'b1;
      chk(pcVector, pcQ.pop_back());
      apb(0, `OFS_SP, 0);
      chk(rdData, 32'h0100);
      chk(stall, 1'b0);
      coreSleeping <= 1'b0;
      rnd = lfsr(rnd);
      pcCurrent <= rnd;
      pcQ.push_back(rnd);
      step(0, 0, 0);
      n++;
    end
    $display("service test done");
    @(posedge clk_sys) srcEvent <= 8'h04;
    @(posedge clk_sys) srcEvent <= 8'h00;
    step(1, 0, 0);
    @(posedge clk_sys);
    chk(globalEnable, 1'b0);
    step(0, 1, 0);
    coreSleeping <= 1'b1;
    repeat (2) @(posedge clk_sys);
    chk(stall, 1'b0);
    coreSleeping <= 1'b0;
    step(0, 0, 0);
    land;
    chk(ack, 8'h04);
    $display("enable test done");
    @(posedge clk_sys) srcEvent <= 8'h02;
    @(posedge clk_sys) srcEvent <= 8'h00;
    apb(1, `OFS_CTRL, {30'h0, vs, 1'b1});
    step(0, 0, 0);
    land;
    chk(ack, 8'h02);
    chk(pcVector, `BOOT_START + 16'h0004);
    apb(0, `OFS_SP, 0);
    chk(rdData, 32'h00fc);
    $display("nesting test done");
    appBootLockBit <= 1'b1;
    @(posedge clk_sys) srcEvent <= 8'h08;
    @(posedge clk_sys) srcEvent <= 8'h00;
    apb(1, `OFS_CTRL, {30'h0, vs, 1'b1});
    step(0, 0, 0);
    @(posedge clk_sys);
    chk(stall, 1'b0);
    appBootLockBit <= 1'b0;
    step(0, 0, 0);
    land;
    chk(ack, 8'h08);
    $display("lock test done");
    resetn <= 1'b0;
    bootResetFuse <= 1'b0;
    repeat (6) @(posedge clk_sys);
    resetn <= 1'b1;
    land;
    chk(pcVector, `APP_START);
    $display("second reset test done");
    summarize;
  end
endmodule
bind cpu_interrupt_sequencer cpu_interrupt_sequencer_assertions
  cpu_interrupt_sequencer_assertions_i (.clk_sys, .resetn, .srcAck, .instrDone, .instrCli,
  .instrSei, .instrReti, .coreSleeping, .pcCurrent, .bootResetFuse, .stackRdata, .stackWe,
  .stackRe, .stackAddr, .stackWdata, .pcLoad, .pcVector, .stall, .globalEnable);
`default_nettype wire
